// ### hdl/tmc_map.svh
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
// Register byte offsets
`define TMC_OFS_CTRL 12'h000
`define TMC_OFS_DCTL 12'h004
`define TMC_OFS_MAP 12'h008
`define TMC_OFS_STAT 12'h00C
`define TMC_OFS_HDR0 12'h010
// Field positions and reset values
`define TMC_CTRL_ECRC_BIT 0
`define TMC_CTRL_UPPORT_LSB 1
`define TMC_MPS_LSB 5
`define TMC_CTRL_RST 32'h0000_0000
`define TMC_DCTL_RST 32'h0000_0000
`define TMC_MAP_RST 32'h0000_0001
// Payload limit in doublewords for code 0 (128 bytes)
`define TMC_MPS_BASE_DW 11'h020
`endif

// ### hdl/tmc_pkg.sv
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_OUT_NONE = 2'h0,
    TMC_OUT_CORR = 2'h1,
    TMC_OUT_NONFATAL = 2'h2,
    TMC_OUT_FATAL = 2'h3
  } tmc_class_t;

  // One checked TLP as presented by a port stack
  typedef struct packed {
    logic [2:0] port;
    logic egress;
    logic [2:0] fmt;
    logic [4:0] ttype;
    logic [2:0] tc;
    logic td;
    logic ep;
    logic [1:0] attr;
    logic [9:0] length;
    logic [3:0] last_be;
    logic [7:0] msg_code;
    logic [10:0] rx_payload_dw;
    logic [10:0] rx_total_dw;
    logic ecrc_bad;
    logic to_switch;
    logic ur_np;
    logic unexp_cpl;
    logic [31:0] hdr0;
  } tmc_tlp_t;

  typedef struct packed {
    logic valid;
    tmc_class_t cls;
    logic [2:0] port;
    logic malformed;
    logic advisory;
  } tmc_result_t;
endpackage : tmc_pkg

// ### hdl/tmc_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmc_map.svh"
module tmc_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // TLP to check, one per cycle
  input wire logic tlp_valid,
  input wire tmc_pkg::tmc_tlp_t tlp,
  // Outcome to error reporting
  output var tmc_pkg::tmc_result_t result
);
  import tmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_q, dctl_q, map_q, hdr_q;
  logic [3:0] stat_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic ecrc_en;
  logic [2:0] up_port;
  logic [10:0] mps_dw;

  assign ecrc_en = ctrl_q[`TMC_CTRL_ECRC_BIT];
  assign up_port = ctrl_q[`TMC_CTRL_UPPORT_LSB +: 3];
  // Code 0..5 gives 128..4096 bytes; larger codes clamp to the top size
  assign mps_dw = (dctl_q[`TMC_MPS_LSB +: 3] > 3'h5) ? 11'h400 :
                  11'(`TMC_MPS_BASE_DW << dctl_q[`TMC_MPS_LSB +: 3]);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY; unmapped reads give zero
  logic addr_ok;
  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `TMC_CTRL_RST;
      dctl_q <= `TMC_DCTL_RST;
      map_q <= `TMC_MAP_RST;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        `TMC_OFS_CTRL: ctrl_q <= hwdata & 32'h0000_000F;
        `TMC_OFS_DCTL: dctl_q <= hwdata & 32'h0000_00E0;
        `TMC_OFS_MAP: map_q <= hwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      unique case (haddr)
        `TMC_OFS_CTRL: hrdata <= ctrl_q;
        `TMC_OFS_DCTL: hrdata <= dctl_q;
        `TMC_OFS_MAP: hrdata <= map_q;
        `TMC_OFS_STAT: hrdata <= {28'h000_0000, stat_q};
        `TMC_OFS_HDR0: hrdata <= hdr_q;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks, all combinational on the presented TLP
  logic [3:0] sub;
  logic [2:0] rt;
  logic has_data, is_mem, is_io, is_cfg, is_msg, is_cpl, is_tcfg;
  logic fmt_ok, on_up, class_ok, len_dw_one;
  logic bad_fmt, bad_mps, bad_len, bad_td, bad_io, bad_cfg, bad_msgtc, bad_route;
  logic ingress_mal, egress_mal, malformed, ecrc_fail;
  logic [10:0] exp_total, hdr_dw, len_dw;

  assign has_data = tlp.fmt[1];
  assign rt = tlp.ttype[2:0];
  assign on_up = (tlp.port == up_port);
  assign len_dw = (tlp.length == 10'h000) ? 11'h400 : {1'b0, tlp.length};
  assign len_dw_one = (tlp.length == 10'h001);
  assign hdr_dw = tlp.fmt[0] ? 11'h004 : 11'h003;

  always_comb begin
    sub = 4'h0;
    is_mem = (tlp.ttype == 5'h00) || (tlp.ttype == 5'h01);
    is_io = (tlp.ttype == 5'h02);
    is_cfg = (tlp.ttype == 5'h04) || (tlp.ttype == 5'h05);
    is_msg = (tlp.ttype[4:3] == 2'b10);
    is_cpl = (tlp.ttype == 5'h0A) || (tlp.ttype == 5'h0B);
    is_tcfg = (tlp.ttype == 5'h1B);
    fmt_ok = 1'b0;
    if (is_mem) fmt_ok = !tlp.fmt[2] && !(tlp.ttype[0] && tlp.fmt[1]);
    else if (is_io || is_cfg) fmt_ok = (tlp.fmt[2:1] == 2'b00) || (tlp.fmt == 3'b010);
    else if (is_msg) fmt_ok = tlp.fmt[0] && !tlp.fmt[2];
    else if (is_cpl) fmt_ok = (tlp.fmt == 3'b000) || (tlp.fmt == 3'b010);
    else if (is_tcfg) fmt_ok = (tlp.fmt == 3'b001) || (tlp.fmt == 3'b011);
    sub = tlp.msg_code[7:4];
  end

  assign bad_fmt = !fmt_ok;
  assign bad_mps = has_data && (len_dw > mps_dw);
  assign bad_len = has_data && (len_dw != tlp.rx_payload_dw);
  assign exp_total = hdr_dw + (has_data ? len_dw : 11'h000) + 11'h001;
  assign bad_td = tlp.td && (tlp.rx_total_dw != exp_total);
  assign bad_io = is_io && !(len_dw_one && tlp.tc == 3'h0 && tlp.attr == 2'h0
                  && tlp.last_be == 4'h0);
  assign bad_cfg = is_cfg && !(len_dw_one && tlp.tc == 3'h0 && tlp.attr == 2'h0
                   && tlp.last_be == 4'h0);
  // INTx 0x2x, PM 0x1x, error 0x3x, unlock 0x00, set power limit 0x50
  assign bad_msgtc = is_msg && (tlp.tc != 3'h0) && (sub == 4'h1 || sub == 4'h2
                     || sub == 4'h3 || tlp.msg_code == 8'h00
                     || tlp.msg_code == 8'h50);
  assign bad_route = is_msg && (
      (rt == 3'h0 && on_up) ||
      (rt == 3'h3 && !on_up) ||
      (rt == 3'h5 && (on_up || tlp.msg_code != 8'h1B)) ||
      (sub == 4'h2 && on_up)) ||
      (is_tcfg && !on_up);
  assign class_ok = map_q[tlp.tc];

  assign ingress_mal = bad_fmt || bad_mps || bad_len || bad_td || bad_io || bad_cfg
                       || bad_msgtc || bad_route || !class_ok;
  assign egress_mal = !class_ok;
  assign malformed = tlp.egress ? egress_mal : ingress_mal;
  assign ecrc_fail = ecrc_en && tlp.td && tlp.ecrc_bad && !tlp.egress;

  ////////////////////////////////////////////////////////////////////////////
  // Outcome: fatal beats non-fatal beats correctable
  tmc_class_t cls_d;
  logic adv_d;
  always_comb begin
    cls_d = TMC_OUT_NONE;
    adv_d = 1'b0;
    if (malformed) begin
      cls_d = TMC_OUT_FATAL;
    end else if ((ecrc_fail && tlp.to_switch) || (tlp.ep && tlp.to_switch)) begin
      cls_d = TMC_OUT_NONFATAL;
    end else if (ecrc_fail || (tlp.ep && !tlp.egress) || tlp.ur_np || tlp.unexp_cpl) begin
      cls_d = TMC_OUT_CORR;
      adv_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= '0;
    end else begin
      result.valid <= tlp_valid;
      result.cls <= tlp_valid ? cls_d : TMC_OUT_NONE;
      result.port <= tlp.port;
      result.malformed <= tlp_valid && malformed;
      result.advisory <= tlp_valid && adv_d;
    end
  end

  // Header log and sticky status; a new event wins over a status clear
  logic stat_clr;
  assign stat_clr = wr_pend_q && (wr_addr_q == `TMC_OFS_STAT);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 4'h0;
      hdr_q <= 32'h0000_0000;
    end else begin
      if (tlp_valid && malformed) begin
        hdr_q <= tlp.hdr0;
      end
      stat_q <= (stat_clr ? (stat_q & ~hwdata[3:0]) : stat_q)
                | ({4{tlp_valid}} & {malformed, cls_d == TMC_OUT_NONFATAL,
                   cls_d == TMC_OUT_CORR, ecrc_fail});
    end
  end
endmodule : tmc_checker
`default_nettype wire

// ### sim/tmc_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_checker_sva (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Checked TLP and its outcome
  input wire logic tlp_valid,
  input wire tmc_pkg::tmc_tlp_t tlp,
  input wire tmc_pkg::tmc_result_t result
);
  import tmc_pkg::*;
  logic ing;
  // Egress only looks at the class map, so field checks watch ingress alone
  assign ing = tlp_valid && !tlp.egress;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////
  a_valid_follow: assert property (##1 result.valid == $past(tlp_valid))
    else $error("result valid not one cycle after tlp");
  a_port_follow: assert property (tlp_valid |=> result.port == $past(tlp.port))
    else $error("result port differs from receiving port");
  a_fatal_malf: assert property (result.malformed |-> result.cls == TMC_OUT_FATAL)
    else $error("malformed tlp not fatal");
  a_idle_none: assert property (!result.valid |-> result.cls == TMC_OUT_NONE)
    else $error("class reported without a tlp");
  a_bad_type: assert property (ing && tlp.fmt == 3'h0 && tlp.ttype == 5'h03 |=>
    result.malformed) else $error("reserved type accepted");
  a_len_match: assert property (ing && tlp.fmt[1] &&
    {tlp.length == 10'h0, tlp.length} != tlp.rx_payload_dw |=> result.malformed)
    else $error("length mismatch accepted");
  a_io_len: assert property (ing && !tlp.fmt[2] && tlp.ttype == 5'h02 &&
    tlp.length != 10'h1 |=> result.malformed) else $error("long io accepted");
  a_cfg_attr: assert property (ing && !tlp.fmt[2] && tlp.ttype[4:1] == 4'h2 &&
    tlp.attr != 2'h0 |=> result.malformed) else $error("cfg attr accepted");
endmodule : tmc_checker_sva
bind tmc_checker tmc_checker_sva u_sva (.hclk(hclk), .hresetn(hresetn),
  .tlp_valid(tlp_valid), .tlp(tlp), .result(result));
`default_nettype wire

// ### sim/tmc_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_link_partner (
  // Clock
  input wire logic hclk,
  // TLP toward the port stack
  output var logic tlp_valid,
  output var tmc_pkg::tmc_tlp_t tlp
);
  import tmc_pkg::*;
  initial begin
    tlp_valid = 1'h0;
    tlp = '0;
  end
  task send(input tmc_tlp_t t);
    @(posedge hclk);
    tlp_valid <= 1'h1;
    tlp <= t;
    @(posedge hclk);
    tlp_valid <= 1'h0;
    // Fields flip when idle so nothing can lean on a stale header
    tlp <= ~t;
  endtask : send
endmodule : tmc_link_partner
`default_nettype wire

// ### sim/tmc_checker_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_checker_tb_top;
  import tmc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tlp_valid;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, q;
  tmc_tlp_t tlp, p, b;
  tmc_result_t result;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  tmc_link_partner lp (.hclk(hclk), .tlp_valid(tlp_valid), .tlp(tlp));
  tmc_checker dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tlp_valid(tlp_valid), .tlp(tlp), .result(result));
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      results;
    end
  end
  ////////////////////////////////////////
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, s, e);
    end
  endtask : chk
  // Single word transfer; no wait count assumed, the timeout ends a hang
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask : bus
  function automatic tmc_tlp_t mk(input logic [2:0] f, input logic [4:0] t,
      input logic [2:0] pt, input logic [2:0] c, input logic [7:0] m);
    mk = p;
    mk.fmt = f;
    mk.ttype = t;
    mk.port = pt;
    mk.tc = c;
    mk.msg_code = m;
    mk.rx_payload_dw = {10'h0, f[1]};
  endfunction : mk
  task go(input tmc_tlp_t t, input tmc_class_t c);
    lp.send(t);
    #1;
    chk(result.cls, c);
    chk(result.port, t.port);
  endtask : go
  ////////////////////////////////////////
  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    p = '0;
    p.fmt = 3'h2;
    p.port = 3'h1;
    p.length = 10'h1;
    p.rx_payload_dw = 11'h1;
    p.rx_total_dw = 11'h4;
    p.hdr0 = 32'h4000_0001;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h0, 12'h8, 32'h0);
    chk(q, 32'h1);
    bus(1'h0, 12'h100, 32'h0);
    chk(q, 32'h0);
    // Upstream port 0 with checking on; classes 0 and 1 reach channel 0
    bus(1'h1, 12'h0, 32'h1);
    bus(1'h1, 12'h8, 32'h3);
    go(p, TMC_OUT_NONE);
    go(mk(3'h0, 5'h03, 3'h1, 3'h0, 8'h0), TMC_OUT_FATAL);
    go(mk(3'h2, 5'h00, 3'h1, 3'h2, 8'h0), TMC_OUT_FATAL);
    go(mk(3'h1, 5'h10, 3'h1, 3'h1, 8'h20), TMC_OUT_FATAL);
    go(mk(3'h1, 5'h10, 3'h0, 3'h0, 8'h20), TMC_OUT_FATAL);
    go(mk(3'h1, 5'h10, 3'h1, 3'h0, 8'h20), TMC_OUT_NONE);
    go(mk(3'h1, 5'h14, 3'h0, 3'h0, 8'h20), TMC_OUT_FATAL);
    go(mk(3'h1, 5'h13, 3'h1, 3'h0, 8'h19), TMC_OUT_FATAL);
    go(mk(3'h1, 5'h15, 3'h1, 3'h0, 8'h1B), TMC_OUT_NONE);
    go(mk(3'h1, 5'h15, 3'h1, 3'h0, 8'h19), TMC_OUT_FATAL);
    // Legal format, so only the receiving port can make it malformed
    go(mk(3'h1, 5'h1B, 3'h1, 3'h0, 8'h0), TMC_OUT_FATAL);
    go(mk(3'h1, 5'h1B, 3'h0, 3'h0, 8'h0), TMC_OUT_NONE);
    b = mk(3'h0, 5'h02, 3'h1, 3'h0, 8'h0);
    b.length = 10'h2;
    go(b, TMC_OUT_FATAL);
    b = mk(3'h0, 5'h04, 3'h1, 3'h0, 8'h0);
    b.attr = 2'h1;
    go(b, TMC_OUT_FATAL);
    b = p;
    b.length = 10'h2;
    go(b, TMC_OUT_FATAL);
    b.length = 10'h21;
    b.rx_payload_dw = 11'h21;
    go(b, TMC_OUT_FATAL);
    b = p;
    b.td = 1'h1;
    go(b, TMC_OUT_FATAL);
    b.rx_total_dw = 11'h5;
    b.ecrc_bad = 1'h1;
    go(b, TMC_OUT_CORR);
    b.to_switch = 1'h1;
    go(b, TMC_OUT_NONFATAL);
    b.td = 1'h0;
    b.rx_total_dw = 11'h4;
    go(b, TMC_OUT_NONE);
    b = p;
    b.egress = 1'h1;
    b.tc = 3'h2;
    b.hdr0 = 32'h0000_00A5;
    go(b, TMC_OUT_FATAL);
    b = p;
    b.ep = 1'h1;
    go(b, TMC_OUT_CORR);
    chk(result.advisory, 1'h1);
    b = p;
    b.unexp_cpl = 1'h1;
    go(b, TMC_OUT_CORR);
    b = p;
    b.ur_np = 1'h1;
    go(b, TMC_OUT_CORR);
    // Checking off: a bad digest must pass unnoticed
    bus(1'h1, 12'h0, 32'h0);
    b = p;
    b.td = 1'h1;
    b.rx_total_dw = 11'h5;
    b.ecrc_bad = 1'h1;
    go(b, TMC_OUT_NONE);
    bus(1'h0, 12'hC, 32'h0);
    chk(q, 32'hF);
    bus(1'h0, 12'h10, 32'h0);
    chk(q, 32'h0000_00A5);
    bus(1'h1, 12'hC, 32'hF);
    bus(1'h0, 12'hC, 32'h0);
    chk(q, 32'h0);
    results;
  end
endmodule : tmc_checker_tb_top
`default_nettype wire
